// *** src/gpio_port_map.vh ***
// register offsets, reset values and field positions of the gpio port set
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

`define ADDR_W 8
`define PORT_W 8
`define PORT_G_W 5

`define OFS_B_OUT 8'h00
`define OFS_B_DIR 8'h04
`define OFS_B_IN 8'h08
`define OFS_C_OUT 8'h0C
`define OFS_C_DIR 8'h10
`define OFS_C_IN 8'h14
`define OFS_D_OUT 8'h18
`define OFS_D_DIR 8'h1C
`define OFS_D_IN 8'h20
`define OFS_E_OUT 8'h24
`define OFS_E_DIR 8'h28
`define OFS_E_IN 8'h2C
`define OFS_F_OUT 8'h30
`define OFS_F_DIR 8'h34
`define OFS_F_IN 8'h38
`define OFS_G_OUT 8'h3C
`define OFS_G_DIR 8'h40
`define OFS_G_IN 8'h44
`define OFS_CTRL 8'h48
`define OFS_STATUS 8'h4C

`define PORT_RST 8'h00
`define PORT_G_RST 5'h00
`define C_LEGACY_DIR_RST 8'hFF
`define C_LEGACY_OUT_RST 8'h00
`define PULLUP_OFF_BIT 0
`define LEGACY_BIT 0
`define ALIGN_MASK 8'h03
`define RDATA_ZERO 32'h0000_0000

`endif

// *** src/port_regs.v ***
// output value and direction registers plus pin sampling for one port
`timescale 1ns/1ps
module port_regs #(
	parameter WIDTH = 8
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [WIDTH-1:0] out_rst_value,
	input wire [WIDTH-1:0] dir_rst_value,
	input wire write_out,
	input wire write_dir,
	input wire [WIDTH-1:0] wdata,
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] out_value,
	output reg [WIDTH-1:0] direction,
	output reg [WIDTH-1:0] pin_sample
);

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			out_value <= out_rst_value;
			direction <= dir_rst_value;
		end else begin
			if (write_out) begin
				out_value <= wdata;
			end
			if (write_dir) begin
				direction <= wdata;
			end
		end
	end

	// pin levels follow the pins, no reset value
	always @(posedge clk_sys) begin
		pin_sample <= pin_in;
	end

endmodule

// *** src/port_pin_drive.v ***
// pin drive, enable and pull-up for one port, with clockless reset state
`timescale 1ns/1ps
module port_pin_drive #(
	parameter WIDTH = 8
) (
	input wire sys_rst,
	input wire [WIDTH-1:0] out_rst_value,
	input wire [WIDTH-1:0] dir_rst_value,
	input wire [WIDTH-1:0] out_value,
	input wire [WIDTH-1:0] direction,
	input wire pullup_disable,
	input wire force_input,
	input wire alt_enable,
	input wire [WIDTH-1:0] alt_out,
	input wire [WIDTH-1:0] alt_oe,
	output reg [WIDTH-1:0] pin_out,
	output reg [WIDTH-1:0] pin_oe,
	output reg [WIDTH-1:0] pin_pullup
);

	reg [WIDTH-1:0] eff_out;
	reg [WIDTH-1:0] eff_dir;

	always @* begin
		// reset state taken straight from reset values, no clock needed
		eff_out = sys_rst ? out_rst_value : out_value;
		eff_dir = sys_rst ? dir_rst_value : direction;
		pin_out = eff_out & eff_dir;
		pin_oe = eff_dir;
		pin_pullup = ~eff_dir & eff_out & {WIDTH{~pullup_disable}};
		if (alt_enable) begin
			pin_out = alt_out;
			pin_oe = alt_oe;
			pin_pullup = {WIDTH{1'b0}};
		end else if (force_input) begin
			pin_out = {WIDTH{1'b0}};
			pin_oe = {WIDTH{1'b0}};
		end
	end

endmodule

// *** src/gpio_port_register_set.v ***
// apb register set for ports b to g with legacy compatibility mode
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "gpio_port_map.vh"

// Notes on behaviour
// - legacy mode: port c resets as push-pull outputs driving zero
// - pins take reset state during reset even with no clock running
// - legacy mode: port f output and direction registers absent, writes ignored
// - legacy mode: port f pins are inputs only, never driven
// - legacy mode: port g output, direction and input registers unavailable
// - legacy mode: port g pins carry only their alternate functions
// - port g bits 7 to 5 reserved, read as zero
// - input with value one enables pull-up unless globally disabled
module gpio_port_register_set (
	input wire clk_sys,
	input wire sys_rst,
	input wire legacy_mode_fuse,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire [`PORT_W-1:0] pin_b_in,
	output wire [`PORT_W-1:0] pin_b_out,
	output wire [`PORT_W-1:0] pin_b_oe,
	output wire [`PORT_W-1:0] pin_b_pullup,
	input wire [`PORT_W-1:0] pin_c_in,
	output wire [`PORT_W-1:0] pin_c_out,
	output wire [`PORT_W-1:0] pin_c_oe,
	output wire [`PORT_W-1:0] pin_c_pullup,
	input wire [`PORT_W-1:0] pin_d_in,
	output wire [`PORT_W-1:0] pin_d_out,
	output wire [`PORT_W-1:0] pin_d_oe,
	output wire [`PORT_W-1:0] pin_d_pullup,
	input wire [`PORT_W-1:0] pin_e_in,
	output wire [`PORT_W-1:0] pin_e_out,
	output wire [`PORT_W-1:0] pin_e_oe,
	output wire [`PORT_W-1:0] pin_e_pullup,
	input wire [`PORT_W-1:0] pin_f_in,
	output wire [`PORT_W-1:0] pin_f_out,
	output wire [`PORT_W-1:0] pin_f_oe,
	output wire [`PORT_W-1:0] pin_f_pullup,
	input wire [`PORT_G_W-1:0] pin_g_in,
	output wire [`PORT_G_W-1:0] pin_g_out,
	output wire [`PORT_G_W-1:0] pin_g_oe,
	output wire [`PORT_G_W-1:0] pin_g_pullup,
	input wire [`PORT_G_W-1:0] g_alt_out,
	input wire [`PORT_G_W-1:0] g_alt_oe
);

	reg legacy_mode;
	reg global_pullup_disable;
	reg [31:0] next_rdata;

	wire mode_now;
	wire pullup_off_now;
	wire setup_phase;
	wire access_phase;
	wire write_phase;
	wire [`PORT_W-1:0] wbyte;
	wire [`PORT_W-1:0] c_dir_rst;
	wire [`PORT_W-1:0] c_out_rst;

	wire [`PORT_W-1:0] port_b_output_value;
	wire [`PORT_W-1:0] port_b_direction;
	wire [`PORT_W-1:0] port_b_pin_input;
	wire [`PORT_W-1:0] port_c_output_value;
	wire [`PORT_W-1:0] port_c_direction;
	wire [`PORT_W-1:0] port_c_pin_input;
	wire [`PORT_W-1:0] port_d_output_value;
	wire [`PORT_W-1:0] port_d_direction;
	wire [`PORT_W-1:0] port_d_pin_input;
	wire [`PORT_W-1:0] port_e_output_value;
	wire [`PORT_W-1:0] port_e_direction;
	wire [`PORT_W-1:0] port_e_pin_input;
	wire [`PORT_W-1:0] port_f_output_value;
	wire [`PORT_W-1:0] port_f_direction;
	wire [`PORT_W-1:0] port_f_pin_input;
	wire [`PORT_G_W-1:0] port_g_output_value;
	wire [`PORT_G_W-1:0] port_g_direction;
	wire [`PORT_G_W-1:0] port_g_pin_input;

	// true when the address names a mapped, aligned register
	function addr_hit;
		input [`ADDR_W-1:0] addr;
		begin
			addr_hit = ((addr & `ALIGN_MASK) == 8'h00) && (addr <= `OFS_STATUS);
		end
	endfunction

	// write strobe for one register, low byte lane required
	function wr_sel;
		input [`ADDR_W-1:0] addr;
		input [`ADDR_W-1:0] ofs;
		begin
			wr_sel = write_phase && (addr == ofs);
		end
	endfunction

	// zero-extends a port byte into a bus word
	function [31:0] word8;
		input [`PORT_W-1:0] value;
		begin
			word8 = {24'h00_0000, value};
		end
	endfunction

	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign write_phase = access_phase & pwrite & pstrb[0];
	assign pready = 1'b1;
	assign pslverr = access_phase & ~addr_hit(paddr);
	assign wbyte = pwdata[`PORT_W-1:0];

	// mode from the fuse directly while in reset, latched afterwards
	assign mode_now = sys_rst ? legacy_mode_fuse : legacy_mode;
	assign pullup_off_now = global_pullup_disable & ~sys_rst;

	assign c_dir_rst = legacy_mode_fuse ? `C_LEGACY_DIR_RST : `PORT_RST;
	assign c_out_rst = legacy_mode_fuse ? `C_LEGACY_OUT_RST : `PORT_RST;

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			legacy_mode <= legacy_mode_fuse;
			global_pullup_disable <= 1'b0;
		end else if (wr_sel(paddr, `OFS_CTRL)) begin
			global_pullup_disable <= pwdata[`PULLUP_OFF_BIT];
		end
	end

	// read data prepared in setup phase, held through access phase
	always @* begin
		next_rdata = `RDATA_ZERO;
		case (paddr)
			`OFS_B_OUT: begin
				next_rdata = word8(port_b_output_value);
			end
			`OFS_B_DIR: begin
				next_rdata = word8(port_b_direction);
			end
			`OFS_B_IN: begin
				next_rdata = word8(port_b_pin_input);
			end
			`OFS_C_OUT: begin
				next_rdata = word8(port_c_output_value);
			end
			`OFS_C_DIR: begin
				next_rdata = word8(port_c_direction);
			end
			`OFS_C_IN: begin
				next_rdata = word8(port_c_pin_input);
			end
			`OFS_D_OUT: begin
				next_rdata = word8(port_d_output_value);
			end
			`OFS_D_DIR: begin
				next_rdata = word8(port_d_direction);
			end
			`OFS_D_IN: begin
				next_rdata = word8(port_d_pin_input);
			end
			`OFS_E_OUT: begin
				next_rdata = word8(port_e_output_value);
			end
			`OFS_E_DIR: begin
				next_rdata = word8(port_e_direction);
			end
			`OFS_E_IN: begin
				next_rdata = word8(port_e_pin_input);
			end
			`OFS_F_OUT: begin
				if (!legacy_mode) begin
					next_rdata = word8(port_f_output_value);
				end
			end
			`OFS_F_DIR: begin
				if (!legacy_mode) begin
					next_rdata = word8(port_f_direction);
				end
			end
			`OFS_F_IN: begin
				next_rdata = word8(port_f_pin_input);
			end
			`OFS_G_OUT: begin
				if (!legacy_mode) begin
					next_rdata = word8({3'b000, port_g_output_value});
				end
			end
			`OFS_G_DIR: begin
				if (!legacy_mode) begin
					next_rdata = word8({3'b000, port_g_direction});
				end
			end
			`OFS_G_IN: begin
				if (!legacy_mode) begin
					next_rdata = word8({3'b000, port_g_pin_input});
				end
			end
			`OFS_CTRL: begin
				next_rdata[`PULLUP_OFF_BIT] = global_pullup_disable;
			end
			`OFS_STATUS: begin
				next_rdata[`LEGACY_BIT] = legacy_mode;
			end
			default: begin
				next_rdata = `RDATA_ZERO;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			prdata <= `RDATA_ZERO;
		end else if (setup_phase && !pwrite) begin
			prdata <= next_rdata;
		end
	end

	// port b
	port_regs #(.WIDTH(`PORT_W)) regs_b (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_RST),
		.dir_rst_value(`PORT_RST),
		.write_out(wr_sel(paddr, `OFS_B_OUT)),
		.write_dir(wr_sel(paddr, `OFS_B_DIR)),
		.wdata(wbyte),
		.pin_in(pin_b_in),
		.out_value(port_b_output_value),
		.direction(port_b_direction),
		.pin_sample(port_b_pin_input)
	);

	port_pin_drive #(.WIDTH(`PORT_W)) drive_b (
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_RST),
		.dir_rst_value(`PORT_RST),
		.out_value(port_b_output_value),
		.direction(port_b_direction),
		.pullup_disable(pullup_off_now),
		.force_input(1'b0),
		.alt_enable(1'b0),
		.alt_out(`PORT_RST),
		.alt_oe(`PORT_RST),
		.pin_out(pin_b_out),
		.pin_oe(pin_b_oe),
		.pin_pullup(pin_b_pullup)
	);

	// port c, legacy reset drives zero on every pin
	port_regs #(.WIDTH(`PORT_W)) regs_c (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.out_rst_value(c_out_rst),
		.dir_rst_value(c_dir_rst),
		.write_out(wr_sel(paddr, `OFS_C_OUT)),
		.write_dir(wr_sel(paddr, `OFS_C_DIR)),
		.wdata(wbyte),
		.pin_in(pin_c_in),
		.out_value(port_c_output_value),
		.direction(port_c_direction),
		.pin_sample(port_c_pin_input)
	);

	port_pin_drive #(.WIDTH(`PORT_W)) drive_c (
		.sys_rst(sys_rst),
		.out_rst_value(c_out_rst),
		.dir_rst_value(c_dir_rst),
		.out_value(port_c_output_value),
		.direction(port_c_direction),
		.pullup_disable(pullup_off_now),
		.force_input(1'b0),
		.alt_enable(1'b0),
		.alt_out(`PORT_RST),
		.alt_oe(`PORT_RST),
		.pin_out(pin_c_out),
		.pin_oe(pin_c_oe),
		.pin_pullup(pin_c_pullup)
	);

	// port d
	port_regs #(.WIDTH(`PORT_W)) regs_d (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_RST),
		.dir_rst_value(`PORT_RST),
		.write_out(wr_sel(paddr, `OFS_D_OUT)),
		.write_dir(wr_sel(paddr, `OFS_D_DIR)),
		.wdata(wbyte),
		.pin_in(pin_d_in),
		.out_value(port_d_output_value),
		.direction(port_d_direction),
		.pin_sample(port_d_pin_input)
	);

	port_pin_drive #(.WIDTH(`PORT_W)) drive_d (
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_RST),
		.dir_rst_value(`PORT_RST),
		.out_value(port_d_output_value),
		.direction(port_d_direction),
		.pullup_disable(pullup_off_now),
		.force_input(1'b0),
		.alt_enable(1'b0),
		.alt_out(`PORT_RST),
		.alt_oe(`PORT_RST),
		.pin_out(pin_d_out),
		.pin_oe(pin_d_oe),
		.pin_pullup(pin_d_pullup)
	);

	// port e
	port_regs #(.WIDTH(`PORT_W)) regs_e (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_RST),
		.dir_rst_value(`PORT_RST),
		.write_out(wr_sel(paddr, `OFS_E_OUT)),
		.write_dir(wr_sel(paddr, `OFS_E_DIR)),
		.wdata(wbyte),
		.pin_in(pin_e_in),
		.out_value(port_e_output_value),
		.direction(port_e_direction),
		.pin_sample(port_e_pin_input)
	);

	port_pin_drive #(.WIDTH(`PORT_W)) drive_e (
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_RST),
		.dir_rst_value(`PORT_RST),
		.out_value(port_e_output_value),
		.direction(port_e_direction),
		.pullup_disable(pullup_off_now),
		.force_input(1'b0),
		.alt_enable(1'b0),
		.alt_out(`PORT_RST),
		.alt_oe(`PORT_RST),
		.pin_out(pin_e_out),
		.pin_oe(pin_e_oe),
		.pin_pullup(pin_e_pullup)
	);

	// port f, input only in legacy mode
	port_regs #(.WIDTH(`PORT_W)) regs_f (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_RST),
		.dir_rst_value(`PORT_RST),
		.write_out(wr_sel(paddr, `OFS_F_OUT) & ~legacy_mode),
		.write_dir(wr_sel(paddr, `OFS_F_DIR) & ~legacy_mode),
		.wdata(wbyte),
		.pin_in(pin_f_in),
		.out_value(port_f_output_value),
		.direction(port_f_direction),
		.pin_sample(port_f_pin_input)
	);

	port_pin_drive #(.WIDTH(`PORT_W)) drive_f (
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_RST),
		.dir_rst_value(`PORT_RST),
		.out_value(port_f_output_value),
		.direction(port_f_direction),
		.pullup_disable(pullup_off_now),
		.force_input(mode_now),
		.alt_enable(1'b0),
		.alt_out(`PORT_RST),
		.alt_oe(`PORT_RST),
		.pin_out(pin_f_out),
		.pin_oe(pin_f_oe),
		.pin_pullup(pin_f_pullup)
	);

	// port g, five bits, alternate functions only in legacy mode
	port_regs #(.WIDTH(`PORT_G_W)) regs_g (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_G_RST),
		.dir_rst_value(`PORT_G_RST),
		.write_out(wr_sel(paddr, `OFS_G_OUT) & ~legacy_mode),
		.write_dir(wr_sel(paddr, `OFS_G_DIR) & ~legacy_mode),
		.wdata(wbyte[`PORT_G_W-1:0]),
		.pin_in(pin_g_in),
		.out_value(port_g_output_value),
		.direction(port_g_direction),
		.pin_sample(port_g_pin_input)
	);

	port_pin_drive #(.WIDTH(`PORT_G_W)) drive_g (
		.sys_rst(sys_rst),
		.out_rst_value(`PORT_G_RST),
		.dir_rst_value(`PORT_G_RST),
		.out_value(port_g_output_value),
		.direction(port_g_direction),
		.pullup_disable(pullup_off_now),
		.force_input(1'b0),
		.alt_enable(mode_now),
		.alt_out(g_alt_out),
		.alt_oe(g_alt_oe),
		.pin_out(pin_g_out),
		.pin_oe(pin_g_oe),
		.pin_pullup(pin_g_pullup)
	);

endmodule

// *** bench/gpio_port_checker.sv ***
// concurrent checks on the gpio port register set ports
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module gpio_port_checker (
	input wire clk_sys,
	input wire sys_rst,
	input wire legacy_mode_fuse,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`ADDR_W-1:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire [`PORT_W-1:0] pin_b_in,
	input wire [`PORT_W-1:0] pin_b_oe,
	input wire [`PORT_W-1:0] pin_b_pullup,
	input wire [`PORT_W-1:0] pin_c_out,
	input wire [`PORT_W-1:0] pin_c_oe,
	input wire [`PORT_W-1:0] pin_f_oe,
	input wire [`PORT_G_W-1:0] pin_g_out,
	input wire [`PORT_G_W-1:0] pin_g_oe,
	input wire [`PORT_G_W-1:0] g_alt_out,
	input wire [`PORT_G_W-1:0] g_alt_oe
);
	reg legacy_q;
	// mode as latched during reset
	always @(posedge clk_sys) begin
		if (sys_rst)
			legacy_q <= legacy_mode_fuse;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence access;
		psel && penable;
	endsequence
	sequence g_rd;
		psel && !penable && !pwrite && (paddr == `OFS_G_OUT || paddr == `OFS_G_DIR || paddr == `OFS_G_IN);
	endsequence
	sequence b_in_rd;
		psel && !penable && !pwrite && paddr == `OFS_B_IN;
	endsequence
	chk_legacy_c_rst: assert property ($fell(sys_rst) && legacy_q |-> pin_c_oe == 8'hFF && pin_c_out == 8'h00)
		else $error("port c not driving zero after reset");
	chk_reset_clear: assert property ($fell(sys_rst) && !legacy_q |-> pin_b_oe == 8'h00 && pin_c_oe == 8'h00 && pin_b_pullup == 8'h00)
		else $error("pins not cleared after reset");
	chk_f_input_only: assert property (legacy_q |-> pin_f_oe == 8'h00)
		else $error("port f driven in legacy mode");
	chk_g_alt_only: assert property (legacy_q |-> pin_g_oe == g_alt_oe && pin_g_out == g_alt_out)
		else $error("port g not on alternate function");
	chk_pullup_drive: assert property ((pin_b_pullup & pin_b_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	chk_err_align: assert property (access ##0 (paddr[1:0] != 2'b00) |-> pslverr)
		else $error("unaligned access without error");
	chk_err_phase: assert property (!(psel && penable) |-> !pslverr)
		else $error("error outside access phase");
	chk_err_data: assert property (access ##0 (pslverr && !pwrite) |-> prdata == `RDATA_ZERO)
		else $error("error read data not zero");
	chk_g_high_zero: assert property (g_rd ##1 access |-> prdata[31:5] == 27'h000_0000)
		else $error("port g reserved bits not zero");
	chk_pin_sample: assert property (b_in_rd ##1 access |-> prdata == {24'h00_0000, $past(pin_b_in, 2)})
		else $error("port b input read wrong");
endmodule
bind gpio_port_register_set gpio_port_checker u_chk (.clk_sys, .sys_rst, .legacy_mode_fuse, .psel, .penable,
	.pwrite, .paddr, .prdata, .pslverr, .pin_b_in, .pin_b_oe, .pin_b_pullup, .pin_c_out, .pin_c_oe, .pin_f_oe,
	.pin_g_out, .pin_g_oe, .g_alt_out, .g_alt_oe);

// *** bench/pin_board.sv ***
// pin level model: drivers, pull-ups and board signal
`timescale 1ns/1ps
module pin_board #(
	parameter W = 8
) (
	input wire [W-1:0] drv,
	input wire [W-1:0] oe,
	input wire [W-1:0] pu,
	input wire [W-1:0] ext,
	output wire [W-1:0] lvl
);
	// undriven pin follows pull-up, else board level
	assign lvl = (oe & drv) | (~oe & pu) | (~oe & ~pu & ext);
endmodule

// *** bench/gpio_port_register_set_tb_top.sv ***
// self-checking bench for the gpio port register set
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module gpio_port_register_set_tb_top;
	reg clk_sys = 1'b0;
	reg sys_rst = 1'b1;
	reg legacy_mode_fuse = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [7:0] a;
	reg [31:0] pwdata = 32'h0000_0000;
	reg [47:0] ext = 48'h0000_0000_0000;
	reg [4:0] g_alt_out = 5'h00;
	reg [4:0] g_alt_oe = 5'h00;
	wire pready;
	wire pslverr;
	wire [31:0] prdata;
	wire [47:0] p_in, p_out, p_oe, p_pu;
	integer err_count = 0;
	integer comparisons = 0;
	integer p, i;
	reg [31:0] rd, v, d, ex;
	reg er;
	initial forever #50 clk_sys = ~clk_sys;
	assign {p_out[47:45], p_oe[47:45], p_pu[47:45]} = 9'h000;
	gpio_port_register_set dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .legacy_mode_fuse(legacy_mode_fuse),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .g_alt_out(g_alt_out), .g_alt_oe(g_alt_oe),
		.pin_b_in(p_in[7:0]), .pin_b_out(p_out[7:0]), .pin_b_oe(p_oe[7:0]), .pin_b_pullup(p_pu[7:0]),
		.pin_c_in(p_in[15:8]), .pin_c_out(p_out[15:8]), .pin_c_oe(p_oe[15:8]), .pin_c_pullup(p_pu[15:8]),
		.pin_d_in(p_in[23:16]), .pin_d_out(p_out[23:16]), .pin_d_oe(p_oe[23:16]), .pin_d_pullup(p_pu[23:16]),
		.pin_e_in(p_in[31:24]), .pin_e_out(p_out[31:24]), .pin_e_oe(p_oe[31:24]), .pin_e_pullup(p_pu[31:24]),
		.pin_f_in(p_in[39:32]), .pin_f_out(p_out[39:32]), .pin_f_oe(p_oe[39:32]), .pin_f_pullup(p_pu[39:32]),
		.pin_g_in(p_in[44:40]), .pin_g_out(p_out[44:40]), .pin_g_oe(p_oe[44:40]), .pin_g_pullup(p_pu[44:40]));
	pin_board #(.W(48)) board (.drv(p_out), .oe(p_oe), .pu(p_pu), .ext(ext), .lvl(p_in));
	task finish_test;
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input string n, input [31:0] e, input [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input w, input [7:0] ad, input [31:0] wd);
		integer n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20) begin
			n = n + 1;
			@(posedge clk_sys);
		end
		if (n == 20)
			err_count = err_count + 1;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd_chk(input string n, input [7:0] ad, input [31:0] e);
		apb(1'b0, ad, `RDATA_ZERO);
		check(n, e, rd);
	endtask
	function [7:0] ofs(input integer q);
		ofs = `OFS_B_OUT + q[5:0] * 8'd12;
	endfunction
	function [7:0] msk(input integer q);
		msk = (q == 5) ? 8'h1F : 8'hFF;
	endfunction
	function [7:0] lvl_exp(input [7:0] o, input [7:0] dr, input [7:0] x);
		lvl_exp = o | (~dr & x);
	endfunction
	initial begin
		#2_000_000;
		err_count = err_count + 1;
		finish_test;
	end
	initial begin
		void'($urandom(32'h54fc_9257));
		#1;
		check("c_oe", 32'h0000_00FF, p_oe[15:8]);
		check("c_out", `RDATA_ZERO, p_out[15:8]);
		check("f_oe", `RDATA_ZERO, p_oe[39:32]);
		check("b_oe", `RDATA_ZERO, p_oe[7:0]);
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_chk("status", `OFS_STATUS, 32'h0000_0001);
		// port f and g registers ignore writes and read zero in this mode, port f input skipped
		for (i = 0; i < 6; i = i + 1) begin
			a = `OFS_F_OUT + i[5:0] * 8'd4;
			if (i != 2) begin
				apb(1'b1, a, 32'h0000_00FF);
				rd_chk("legacy reg", a, `RDATA_ZERO);
			end
		end
		check("f_oe", `RDATA_ZERO, p_oe[39:32]);
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge clk_sys);
			v = $urandom;
			g_alt_out <= v[4:0];
			g_alt_oe <= v[9:5];
			@(negedge clk_sys);
			check("g_oe", v[9:5], p_oe[44:40]);
			check("g_out", v[4:0], p_out[44:40]);
		end
		@(posedge clk_sys);
		legacy_mode_fuse <= 1'b0;
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_chk("status", `OFS_STATUS, `RDATA_ZERO);
		for (p = 0; p < 6; p = p + 1) begin
			rd_chk("out rst", ofs(p), `RDATA_ZERO);
			rd_chk("dir rst", ofs(p) + 8'd4, `RDATA_ZERO);
			for (i = 0; i < 6; i = i + 1) begin
				v = (i == 0) ? 32'h0000_00FF : (i == 1) ? `RDATA_ZERO : $urandom;
				d = (i == 0) ? `RDATA_ZERO : (i == 1) ? 32'h0000_00FF : $urandom;
				ex = $urandom;
				apb(1'b1, ofs(p), v);
				apb(1'b1, ofs(p) + 8'd4, d);
				ext[p*8 +: 8] <= ex[7:0];
				rd_chk("out", ofs(p), v & msk(p));
				rd_chk("dir", ofs(p) + 8'd4, d & msk(p));
				check("oe", d & msk(p), p_oe[p*8 +: 8]);
				check("pullup", ~d & v & msk(p), p_pu[p*8 +: 8]);
				apb(1'b1, ofs(p) + 8'd8, ~v);
				rd_chk("in", ofs(p) + 8'd8, lvl_exp(v[7:0], d[7:0], ex[7:0]) & msk(p));
				rd_chk("out kept", ofs(p), v & msk(p));
			end
		end
		apb(1'b1, `OFS_B_OUT, 32'h0000_00FF);
		apb(1'b1, `OFS_B_DIR, `RDATA_ZERO);
		apb(1'b1, `OFS_CTRL, 32'h0000_0001);
		@(negedge clk_sys);
		check("pullup off", `RDATA_ZERO, p_pu[7:0]);
		apb(1'b1, `OFS_CTRL, `RDATA_ZERO);
		@(negedge clk_sys);
		check("pu on", 32'h0000_00FF, p_pu[7:0]);
		rd_chk("err data", 8'h01, `RDATA_ZERO);
		check("err", 32'h0000_0001, er);
		apb(1'b1, 8'h80, `RDATA_ZERO);
		check("err", 32'h0000_0001, er);
		rd_chk("b out", `OFS_B_OUT, 32'h0000_00FF);
		finish_test;
	end
endmodule
